// file: dv/tmo_ctl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tmo_ctl_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic stb = 1'b0;
	logic tone = 1'b0;
	logic cv = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rq;
	logic ev;
	logic ns;
	logic sp;
	logic mute;
	logic [1:0] lbl;
	wire logic [13:0] ep;
	wire logic [13:0] dp;
	wire logic dstb;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	always #25 clk = ~clk;
	tmo_ctl dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_enc_strobe(stb), .i_enc_tone(tone), .i_enc_char_valid(cv),
		.i_enc_char(5'h13), .i_enc_baud(1'b0), .i_enc_lag(7'h2A),
		.i_enc_gain(4'h9), .i_enc_rate(2'h1), .o_enc_valid(ev),
		.o_enc_label(lbl), .o_enc_lag(ep[7:1]), .o_enc_gain(ep[11:8]),
		.o_enc_bit171(ep[0]), .o_enc_rate(ep[13:12]), .o_enc_ns_en(ns),
		.i_dec_strobe(dstb), .i_dec_rate(dp[13:12]), .i_dec_gain(dp[11:8]),
		.i_dec_lag(dp[7:1]), .i_dec_bit171(dp[0]), .o_dec_speech_en(sp),
		.o_dec_mute(mute), .o_dec_regen(), .o_dec_char_valid(),
		.o_dec_char(), .o_dec_baud());
	tmo_peer peer (.i_ref_clk(clk), .i_valid(ev), .i_pkt(ep),
		.o_strobe(dstb), .o_pkt(dp));
	task automatic wrap_up;
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, x);
		num_checks++;
		if (x !== e) begin
			err_count++;
			$display("wrong value %s exp %0h got %0h", s, e, x);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 rq = rdata;
	endtask
	task automatic frame(input logic t, v);
		@(posedge clk);
		tone <= t;
		cv <= v;
		stb <= 1'b1;
		@(posedge clk);
		stb <= 1'b0;
		#1;
		for (int k = 0; k < 40 && ev !== 1'b1; k++) @(posedge clk) #1;
		chk("valid", 1, ev);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			wrap_up;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		acc(1'b0, tmo_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h1, rq);
		acc(1'b0, 8'hF0, 32'h0);
		chk("unmapped", tmo_pkg::RDATA_ZERO, rq);
		frame(1'b0, 1'b0);
		chk("label", tmo_pkg::LABEL_SPEECH, lbl);
		chk("lag", 7'h2A, ep[7:1]);
		chk("ns", 1, ns);
		n = 0;
		repeat (8) begin
			frame(1'b1, 1'b0);
			if (lbl === tmo_pkg::LABEL_IDLE) n++;
		end
		chk("idles", 1, n >= 4);
		chk("idle", tmo_pkg::LAG_IDLE, ep[7:1]);
		chk("gain", tmo_pkg::GAIN_ZERO, ep[11:8]);
		chk("rate", tmo_pkg::RATE_FULL, ep[13:12]);
		chk("ns", 0, ns);
		chk("baud", 0, ep[0]);
		repeat (3) @(posedge clk);
		#1;
		chk("mute", 1, mute);
		chk("speech", 0, sp);
		n = 0;
		repeat (8) begin
			frame(1'b1, 1'b1);
			if (lbl === tmo_pkg::LABEL_CHAR && ep[5:1] === 5'h13) n++;
		end
		chk("reps", 1, n >= 6);
		repeat (3) @(posedge clk);
		#1;
		chk("unmute", 0, mute);
		acc(1'b1, tmo_pkg::ADDR_CTRL, 32'h0);
		frame(1'b1, 1'b1);
		chk("off", tmo_pkg::LABEL_SPEECH, lbl);
		chk("offlag", 7'h2A, ep[7:1]);
		wrap_up;
	end
endmodule // tmo_ctl_tb
`default_nettype wire

// file: dv/tmo_peer.sv
`timescale 1ns/1ns
`default_nettype none
module tmo_peer (
	// Clock
	input wire logic i_ref_clk,
	// Packet from the encoder
	input wire logic i_valid,
	input wire logic [13:0] i_pkt,
	// Packet to the decoder
	output logic o_strobe,
	output logic [13:0] o_pkt
);
	// Fields toggle between packets so stale data is never reused.
	always_ff @(posedge i_ref_clk) begin
		o_strobe <= i_valid;
		o_pkt <= i_valid ? i_pkt : ~o_pkt;
	end
endmodule // tmo_peer
`default_nettype wire

// file: verilog/tmo_ctl.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1 - Every encoder frame gets exactly one label.
// RULE2 - Speech mode without tones, teletype with tones.
// RULE3 - Enable bit off gives plain codec behaviour.
// RULE4 - Each character is sent at least six times.
// RULE5 - Teletype frames carry code, zero codebook gain.
// RULE6 - Teletype frames: full rate, noise suppression off.
// RULE7 - Decoder keeps history of gain and lag.
// RULE8 - Zero gain plus teletype lag stops speech.
// RULE9 - Speech frames pass unchanged, no added delay.
// RULE10 - Onset frames are idle until character known.
// RULE11 - Idle message within two frames of tones.
// RULE12 - Idle sent four frames, until character or speech.
// RULE13 - Decoder infers mode from gain and lag only; the code also uses the packet rate and the decoder mode.
// RULE14 - Decoder enters teletype on idle messages.
// RULE15 - Decoder mutes until characters or speech return.
// RULE16 - Eighth rate in teletype mode means idle.
// RULE17 - Lag holds header in two MSBs, character below.
// RULE18 - Baud bit 0 slow, 1 fast; idle repeats it.
// RULE19 - No eighth-rate frame right after full rate.
// RULE20 - Reset returns modes, counters, history to start.
module tmo_ctl (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// Encoder frame input
	input wire logic i_enc_strobe,
	input wire logic i_enc_tone,
	input wire logic i_enc_char_valid,
	input wire logic [4:0] i_enc_char,
	input wire logic i_enc_baud,
	input wire logic [6:0] i_enc_lag,
	input wire logic [3:0] i_enc_gain,
	input wire logic [1:0] i_enc_rate,
	// Encoder frame output
	output logic o_enc_valid,
	output logic [1:0] o_enc_label,
	output logic [6:0] o_enc_lag,
	output logic [3:0] o_enc_gain,
	output logic o_enc_bit171,
	output logic [1:0] o_enc_rate,
	output logic o_enc_ns_en,
	// Decoder packet input
	input wire logic i_dec_strobe,
	input wire logic [1:0] i_dec_rate,
	input wire logic [3:0] i_dec_gain,
	input wire logic [6:0] i_dec_lag,
	input wire logic i_dec_bit171,
	// Decoder control output
	output logic o_dec_speech_en,
	output logic o_dec_mute,
	output logic o_dec_regen,
	output logic o_dec_char_valid,
	output logic [4:0] o_dec_char,
	output logic o_dec_baud
);
	tmo_hist_if hif ();

	// Control register state.
	logic ctrl_en_reg;
	logic ctrl_en_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Encoder state.
	tmo_pkg::tmo_enc_state_t enc_state_reg;
	tmo_pkg::tmo_enc_state_t enc_state_next;
	logic [2:0] idle_cnt_reg;
	logic [2:0] idle_cnt_next;
	logic [4:0] reps_reg;
	logic [4:0] reps_next;
	logic [4:0] char_reg;
	logic [4:0] char_next;
	logic [1:0] hdr_reg;
	logic [1:0] hdr_next;
	logic gap_reg;
	logic gap_next;
	logic baud_reg;
	logic baud_next;
	logic idle_done;
	logic reps_done;

	// Encoder frame outputs.
	logic valid_reg;
	logic valid_next;
	logic [1:0] label_reg;
	logic [1:0] label_next;
	logic [6:0] lag_reg;
	logic [6:0] lag_next;
	logic [3:0] gain_reg;
	logic [3:0] gain_next;
	logic bit171_reg;
	logic bit171_next;
	logic ns_reg;
	logic ns_next;
	logic [1:0] rate_req;
	logic [1:0] rate_ok;
	logic [1:0] rate_reg;
	logic [1:0] rate_next;

	// Decoder state.
	tmo_pkg::tmo_dec_state_t dec_state_reg;
	tmo_pkg::tmo_dec_state_t dec_state_next;
	logic regen_reg;
	logic regen_next;
	logic [4:0] dchar_reg;
	logic [4:0] dchar_next;
	logic dchar_valid_reg;
	logic dchar_valid_next;
	logic dbaud_reg;
	logic dbaud_next;
	logic [1:0] dec_cls;
	logic dec_repeat;

	// Classifies a received packet from its rate, gain and lag fields and the decoder mode.
	function automatic logic [1:0] dec_class(input logic tele,
		input logic [1:0] rate, input logic [3:0] gain,
		input logic [6:0] lag);
		logic [1:0] hdr;
		hdr = lag[tmo_pkg::LAG_HDR_LSB +: 2];
		dec_class = tmo_pkg::LABEL_SPEECH;
		if (tele && rate == tmo_pkg::RATE_EIGHTH) begin
			dec_class = tmo_pkg::LABEL_IDLE; // RULE16
		end else if (rate != tmo_pkg::RATE_EIGHTH &&
			gain == tmo_pkg::GAIN_ZERO) begin
			if (lag == tmo_pkg::LAG_IDLE) begin
				dec_class = tmo_pkg::LABEL_IDLE; // RULE13
			end else if (hdr == tmo_pkg::HDR_FIRST ||
				hdr == tmo_pkg::HDR_LAST) begin
				dec_class = tmo_pkg::LABEL_CHAR; // RULE13
			end
		end
	endfunction

	// Register port; read data stand only in the cycle after the strobe.
	always_comb begin
		ctrl_en_next = ctrl_en_reg;
		rdata_next = tmo_pkg::RDATA_ZERO;
		if (i_reg_wr && i_reg_addr == tmo_pkg::ADDR_CTRL) begin
			ctrl_en_next = i_reg_wdata[tmo_pkg::CTRL_EN_BIT]; // RULE3
		end
		if (i_reg_rd && i_reg_addr == tmo_pkg::ADDR_CTRL) begin
			rdata_next[tmo_pkg::CTRL_EN_BIT] = ctrl_en_reg;
			rdata_next[tmo_pkg::CTRL_BAUD_BIT] = baud_reg;
		end else if (i_reg_rd && i_reg_addr == tmo_pkg::ADDR_STATUS) begin
			rdata_next[tmo_pkg::ST_ENC_LSB +: 2] = enc_state_reg;
			rdata_next[tmo_pkg::ST_DEC_BIT] =
				dec_state_reg == tmo_pkg::DEC_TELETYPE;
			rdata_next[tmo_pkg::ST_REGEN_BIT] = regen_reg;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctrl_en_reg <= tmo_pkg::CTRL_EN_RESET; // RULE20
			rdata_reg <= tmo_pkg::RDATA_ZERO;
		end else begin
			ctrl_en_reg <= ctrl_en_next;
			rdata_reg <= rdata_next;
		end
	end

	// A run of idle frames must reach its minimum before it may end.
	assign idle_done = idle_cnt_reg >= tmo_pkg::IDLE_MIN; // RULE12
	assign reps_done = reps_reg >= tmo_pkg::CHAR_REPS; // RULE4

	// Encoder: one label per frame, chosen from the state it moves to.
	always_comb begin
		enc_state_next = enc_state_reg;
		idle_cnt_next = idle_cnt_reg;
		reps_next = reps_reg;
		char_next = char_reg;
		hdr_next = hdr_reg;
		gap_next = gap_reg;
		baud_next = baud_reg;
		valid_next = i_enc_strobe;
		label_next = label_reg;
		lag_next = lag_reg;
		gain_next = gain_reg;
		bit171_next = bit171_reg;
		ns_next = ns_reg;
		rate_req = i_enc_rate;
		if (i_reg_wr && i_reg_addr == tmo_pkg::ADDR_CTRL) begin
			baud_next = i_reg_wdata[tmo_pkg::CTRL_BAUD_BIT]; // RULE18
		end
		if (i_enc_strobe) begin
			unique case (enc_state_reg)
				tmo_pkg::ENC_SPEECH: begin
					if (i_enc_tone) begin
						enc_state_next = tmo_pkg::ENC_IDLE; // RULE10
						idle_cnt_next = 3'h1; // RULE11
						gap_next = 1'b1;
					end
				end
				tmo_pkg::ENC_IDLE: begin
					if (!idle_done) begin
						idle_cnt_next = idle_cnt_reg + 3'h1;
					end
					if (!i_enc_tone && idle_done) begin
						enc_state_next = tmo_pkg::ENC_SPEECH; // RULE2
					end else if (i_enc_tone && !i_enc_char_valid) begin
						gap_next = 1'b1;
					end else if (i_enc_tone && idle_done &&
						(gap_reg || i_enc_char != char_reg)) begin
						enc_state_next = tmo_pkg::ENC_CHAR;
					end
				end
				tmo_pkg::ENC_CHAR: begin
					if (!reps_done) begin
						reps_next = reps_reg + 5'h01; // RULE4
					end else if (reps_reg == tmo_pkg::CHAR_REPS_MAX) begin
						enc_state_next = tmo_pkg::ENC_IDLE;
						idle_cnt_next = 3'h1;
					end else if (!i_enc_tone) begin
						enc_state_next = tmo_pkg::ENC_SPEECH; // RULE2
					end else if (!i_enc_char_valid) begin
						enc_state_next = tmo_pkg::ENC_IDLE;
						idle_cnt_next = 3'h1;
						gap_next = 1'b1;
					end else if (i_enc_char != char_reg) begin
						gap_next = 1'b1;
					end else begin
						reps_next = reps_reg + 5'h01;
					end
				end
			endcase
			if (!ctrl_en_reg) begin
				enc_state_next = tmo_pkg::ENC_SPEECH; // RULE3
			end
			// A new character restarts the count and steps the header.
			if (enc_state_next == tmo_pkg::ENC_CHAR &&
				(enc_state_reg != tmo_pkg::ENC_CHAR || gap_next)) begin
				reps_next = 5'h01;
				char_next = i_enc_char;
				baud_next = i_enc_baud; // RULE18
				gap_next = 1'b0;
				hdr_next = (hdr_reg == tmo_pkg::HDR_FIRST) ?
					tmo_pkg::HDR_LAST : tmo_pkg::HDR_FIRST;
			end
			unique case (enc_state_next)
				tmo_pkg::ENC_SPEECH: begin
					label_next = tmo_pkg::LABEL_SPEECH; // RULE1
					lag_next = i_enc_lag; // RULE9
					gain_next = i_enc_gain;
					bit171_next = tmo_pkg::BIT171_SPEECH;
					ns_next = 1'b1;
					rate_req = i_enc_rate;
				end
				tmo_pkg::ENC_IDLE: begin
					label_next = tmo_pkg::LABEL_IDLE; // RULE1
					lag_next = tmo_pkg::LAG_IDLE; // RULE17
					gain_next = tmo_pkg::GAIN_ZERO; // RULE5
					bit171_next = baud_next; // RULE18
					ns_next = 1'b0; // RULE6
					rate_req = tmo_pkg::RATE_FULL; // RULE6
				end
				tmo_pkg::ENC_CHAR: begin
					label_next = tmo_pkg::LABEL_CHAR; // RULE1
					lag_next = {hdr_next, char_next}; // RULE17
					gain_next = tmo_pkg::GAIN_ZERO; // RULE5
					bit171_next = baud_next; // RULE18
					ns_next = 1'b0; // RULE6
					rate_req = tmo_pkg::RATE_FULL; // RULE6
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			enc_state_reg <= tmo_pkg::ENC_SPEECH; // RULE20
			idle_cnt_reg <= 3'h0;
			reps_reg <= 5'h00;
			char_reg <= 5'h00;
			hdr_reg <= tmo_pkg::HDR_LAST;
			gap_reg <= 1'b1;
			baud_reg <= tmo_pkg::BAUD_RESET;
			valid_reg <= 1'b0;
			label_reg <= tmo_pkg::LABEL_SPEECH;
			lag_reg <= 7'h00;
			gain_reg <= 4'h0;
			bit171_reg <= tmo_pkg::BIT171_SPEECH;
			ns_reg <= 1'b1;
		end else begin
			enc_state_reg <= enc_state_next;
			idle_cnt_reg <= idle_cnt_next;
			reps_reg <= reps_next;
			char_reg <= char_next;
			hdr_reg <= hdr_next;
			gap_reg <= gap_next;
			baud_reg <= baud_next;
			valid_reg <= valid_next;
			label_reg <= label_next;
			lag_reg <= lag_next;
			gain_reg <= gain_next;
			bit171_reg <= bit171_next;
			ns_reg <= ns_next;
		end
	end

	tmo_rate u_rate (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_strobe(i_enc_strobe),
		.i_rate(rate_req),
		.o_rate(rate_ok)
	);

	assign rate_next = i_enc_strobe ? rate_ok : rate_reg;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rate_reg <= tmo_pkg::RATE_EIGHTH;
		end else begin
			rate_reg <= rate_next;
		end
	end

	// Decoder history of received gain and lag classes.
	tmo_hist u_hist (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.hif(hif)
	);

	assign dec_cls = dec_class(dec_state_reg == tmo_pkg::DEC_TELETYPE,
		i_dec_rate, i_dec_gain, i_dec_lag);
	assign hif.push = i_dec_strobe && ctrl_en_reg; // RULE7
	assign hif.clear = !ctrl_en_reg;
	assign hif.cls = dec_cls;
	assign hif.code = i_dec_lag;
	// Two matching character packets in a row identify a character.
	assign dec_repeat = dec_cls == tmo_pkg::LABEL_CHAR &&
		hif.prev_cls == tmo_pkg::LABEL_CHAR && hif.prev_code == i_dec_lag;

	always_comb begin
		dec_state_next = dec_state_reg;
		regen_next = regen_reg;
		dchar_next = dchar_reg;
		dchar_valid_next = 1'b0;
		dbaud_next = dbaud_reg;
		if (!ctrl_en_reg) begin
			dec_state_next = tmo_pkg::DEC_SPEECH; // RULE3
			regen_next = 1'b0;
		end else if (i_dec_strobe) begin
			unique case (dec_state_reg)
				tmo_pkg::DEC_SPEECH: begin
					if (dec_cls != tmo_pkg::LABEL_SPEECH) begin
						dec_state_next = tmo_pkg::DEC_TELETYPE; // RULE14
						regen_next = 1'b0; // RULE15
					end
				end
				tmo_pkg::DEC_TELETYPE: begin
					if (dec_cls == tmo_pkg::LABEL_SPEECH &&
						hif.tele_cnt == tmo_pkg::HIST_EMPTY) begin
						dec_state_next = tmo_pkg::DEC_SPEECH; // RULE8
						regen_next = 1'b0;
					end
				end
			endcase
			if (dec_repeat && dec_state_next == tmo_pkg::DEC_TELETYPE) begin
				regen_next = 1'b1; // RULE8
				dchar_valid_next = 1'b1;
				dchar_next = i_dec_lag[tmo_pkg::LAG_HDR_LSB - 1:0];
				// Half-rate packets carry no baud bit; keep the last one.
				if (i_dec_rate == tmo_pkg::RATE_FULL) begin
					dbaud_next = i_dec_bit171; // RULE18
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			dec_state_reg <= tmo_pkg::DEC_SPEECH; // RULE20
			regen_reg <= 1'b0;
			dchar_reg <= 5'h00;
			dchar_valid_reg <= 1'b0;
			dbaud_reg <= tmo_pkg::BAUD_RESET;
		end else begin
			dec_state_reg <= dec_state_next;
			regen_reg <= regen_next;
			dchar_reg <= dchar_next;
			dchar_valid_reg <= dchar_valid_next;
			dbaud_reg <= dbaud_next;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_enc_valid = valid_reg;
	assign o_enc_label = label_reg;
	assign o_enc_lag = lag_reg;
	assign o_enc_gain = gain_reg;
	assign o_enc_bit171 = bit171_reg;
	assign o_enc_rate = rate_reg;
	assign o_enc_ns_en = ns_reg;
	assign o_dec_speech_en = dec_state_reg == tmo_pkg::DEC_SPEECH; // RULE13
	assign o_dec_mute = dec_state_reg == tmo_pkg::DEC_TELETYPE &&
		!regen_reg; // RULE15
	assign o_dec_regen = regen_reg;
	assign o_dec_char_valid = dchar_valid_reg;
	assign o_dec_char = dchar_reg;
	assign o_dec_baud = dbaud_reg;

	sequence s_enc_frame;
		i_enc_strobe;
	endsequence
	sequence s_enc_answer;
		o_enc_valid;
	endsequence
	sequence s_tele_out;
		o_enc_valid && o_enc_label != tmo_pkg::LABEL_SPEECH;
	endsequence
	sequence s_speech_in;
		i_enc_strobe && enc_state_reg == tmo_pkg::ENC_SPEECH &&
			(!ctrl_en_reg || !i_enc_tone);
	endsequence
	sequence s_dec_tele_pkt;
		ctrl_en_reg && i_dec_strobe && dec_cls != tmo_pkg::LABEL_SPEECH;
	endsequence
	sequence s_dec_repeat;
		ctrl_en_reg && i_dec_strobe && dec_repeat;
	endsequence

	property p_answer;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_enc_frame |=> s_enc_answer;
	endproperty
	property p_zero_gain;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_tele_out |-> o_enc_gain == tmo_pkg::GAIN_ZERO;
	endproperty
	property p_full_rate;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_tele_out |-> o_enc_rate == tmo_pkg::RATE_FULL && !o_enc_ns_en;
	endproperty
	property p_speech_pass;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_speech_in |=> o_enc_label == tmo_pkg::LABEL_SPEECH &&
			o_enc_lag == $past(i_enc_lag) && o_enc_gain == $past(i_enc_gain);
	endproperty
	property p_idle_code;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_enc_valid && o_enc_label == tmo_pkg::LABEL_IDLE
		|-> o_enc_lag == tmo_pkg::LAG_IDLE && o_enc_bit171 == baud_reg;
	endproperty
	property p_dec_entry;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_dec_tele_pkt |=> dec_state_reg == tmo_pkg::DEC_TELETYPE;
	endproperty
	property p_unmute;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_dec_repeat |=> !o_dec_mute && o_dec_regen;
	endproperty

	enc_answer_a: assert property (p_answer) else $error("no label"); // RULE1
	tele_gain_a: assert property (p_zero_gain) else $error("gain"); // RULE5
	tele_rate_a: assert property (p_full_rate) else $error("rate"); // RULE6
	speech_pass_a: assert property (p_speech_pass) else $error("pass"); // RULE9
	idle_code_a: assert property (p_idle_code) else $error("idle"); // RULE18
	dec_entry_a: assert property (p_dec_entry) else $error("entry"); // RULE14
	dec_unmute_a: assert property (p_unmute) else $error("mute"); // RULE15
endmodule // tmo_ctl
`default_nettype wire

// file: verilog/tmo_hist.sv
`timescale 1ns/1ns
`default_nettype none
module tmo_hist (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// History port
	tmo_hist_if.hist hif
);
	logic [1:0] cls_reg [tmo_pkg::HIST_DEPTH];
	logic [6:0] code_reg [tmo_pkg::HIST_DEPTH];
	logic [1:0] cls_next [tmo_pkg::HIST_DEPTH];
	logic [6:0] code_next [tmo_pkg::HIST_DEPTH];
	logic [2:0] cnt;

	// Entry 0 is the newest packet; a push shifts the rest along.
	for (genvar k = 0; k < tmo_pkg::HIST_DEPTH; k++) begin : g_slot
		always_comb begin
			cls_next[k] = cls_reg[k];
			code_next[k] = code_reg[k];
			if (hif.clear) begin
				cls_next[k] = tmo_pkg::LABEL_SPEECH;
			end else if (hif.push) begin
				cls_next[k] = (k == 0) ? hif.cls : cls_reg[(k == 0) ? 0 : k - 1]; // RULE7
				code_next[k] = (k == 0) ? hif.code : code_reg[(k == 0) ? 0 : k - 1];
			end
		end
		always_ff @(posedge i_ref_clk) begin
			if (!i_rst_n) begin
				cls_reg[k] <= tmo_pkg::LABEL_SPEECH; // RULE20
				code_reg[k] <= tmo_pkg::LAG_IDLE;
			end else begin
				cls_reg[k] <= cls_next[k];
				code_reg[k] <= code_next[k];
			end
		end
	end

	always_comb begin
		cnt = tmo_pkg::HIST_EMPTY;
		for (int k = 0; k < tmo_pkg::HIST_DEPTH; k++) begin
			cnt = cnt + 3'(cls_reg[k] != tmo_pkg::LABEL_SPEECH);
		end
	end

	assign hif.prev_cls = cls_reg[0];
	assign hif.prev_code = code_reg[0];
	assign hif.tele_cnt = cnt;
endmodule // tmo_hist
`default_nettype wire

// file: verilog/tmo_hist_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tmo_hist_if;
	logic push;
	logic clear;
	logic [1:0] cls;
	logic [6:0] code;
	logic [1:0] prev_cls;
	logic [6:0] prev_code;
	logic [2:0] tele_cnt;
	modport ctl (output push, clear, cls, code,
		input prev_cls, prev_code, tele_cnt);
	modport hist (input push, clear, cls, code,
		output prev_cls, prev_code, tele_cnt);
endinterface // tmo_hist_if
`default_nettype wire

// file: verilog/tmo_pkg.sv
`default_nettype none
package tmo_pkg;
	typedef enum logic [1:0] {ENC_SPEECH, ENC_IDLE, ENC_CHAR} tmo_enc_state_t;
	typedef enum logic {DEC_SPEECH, DEC_TELETYPE} tmo_dec_state_t;
	// Packet rates.
	localparam logic [1:0] RATE_EIGHTH = 2'h0;
	localparam logic [1:0] RATE_HALF = 2'h1;
	localparam logic [1:0] RATE_FULL = 2'h2;
	// Frame labels, also used as packet classes in the decoder.
	localparam logic [1:0] LABEL_SPEECH = 2'h0;
	localparam logic [1:0] LABEL_IDLE = 2'h1;
	localparam logic [1:0] LABEL_CHAR = 2'h2;
	// Pitch lag field layout: header in bits 6:5, character in 4:0.
	localparam int LAG_HDR_LSB = 5;
	localparam logic [1:0] HDR_FIRST = 2'h1;
	localparam logic [1:0] HDR_LAST = 2'h2;
	localparam logic [1:0] HDR_IDLE = 2'h3;
	localparam logic [4:0] CHAR_IDLE = 5'h04;
	localparam logic [6:0] LAG_IDLE = 7'h64;
	localparam logic [3:0] GAIN_ZERO = 4'h0;
	localparam logic BIT171_SPEECH = 1'b0;
	// Frame counts.
	localparam logic [2:0] IDLE_MIN = 3'h4;
	localparam logic [4:0] CHAR_REPS = 5'h06;
	localparam logic [4:0] CHAR_REPS_MAX = 5'h10;
	localparam logic [1:0] FIRST_DELAY = 2'h2;
	localparam int HIST_DEPTH = 4;
	localparam logic [2:0] HIST_EMPTY = 3'h0;
	// Register map.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_BAUD_BIT = 1;
	localparam int ST_ENC_LSB = 0;
	localparam int ST_DEC_BIT = 2;
	localparam int ST_REGEN_BIT = 3;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam logic BAUD_RESET = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0;
endpackage
`default_nettype wire

// file: verilog/tmo_rate.sv
`timescale 1ns/1ns
`default_nettype none
module tmo_rate (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Rate request and legal rate
	input wire logic i_strobe,
	input wire logic [1:0] i_rate,
	output logic [1:0] o_rate
);
	logic [1:0] prev_reg;
	logic [1:0] prev_next;

	// An eighth-rate packet straight after a full-rate one is raised to
	// half rate, since a legacy decoder would treat it as an erasure.
	always_comb begin
		o_rate = i_rate;
		if (prev_reg == tmo_pkg::RATE_FULL && i_rate == tmo_pkg::RATE_EIGHTH) begin
			o_rate = tmo_pkg::RATE_HALF; // RULE19
		end
		prev_next = i_strobe ? o_rate : prev_reg;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			prev_reg <= tmo_pkg::RATE_EIGHTH;
		end else begin
			prev_reg <= prev_next;
		end
	end

	property p_no_drop;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_strobe && prev_reg == tmo_pkg::RATE_FULL
		|-> o_rate != tmo_pkg::RATE_EIGHTH;
	endproperty
	rate_step_a: assert property (p_no_drop) else $error("bad rate step"); // RULE19
endmodule // tmo_rate
`default_nettype wire
